// >>> hbrss_params.svh
// Timing and layout constants for the host-bus reset and system-signal block
`ifndef HBRSS_PARAMS_SVH
`define HBRSS_PARAMS_SVH
`define HBRSS_CLK_PERIOD_NS 5
`define HBRSS_GRST_MIN_MS 2
`define HBRSS_GRST_MIN_CYC ((`HBRSS_GRST_MIN_MS * 1000000 + `HBRSS_CLK_PERIOD_NS - 1) / `HBRSS_CLK_PERIOD_NS)
`define HBRSS_SYNC_STAGES 2
`define HBRSS_CTX_W 8
`define HBRSS_VEND_W 8
`define HBRSS_CTL_W 8
`define HBRSS_CTX_RST 8'h00
`define HBRSS_VEND_RST 8'h00
`define HBRSS_CTL_RST 8'h00
`endif

// >>> hbrss_pkg.sv
// Types for the host-bus reset and system-signal block
`default_nettype none
package hbrss_pkg;
   typedef enum logic [1:0] {
      HBRSS_ST_GRST = 2'b00,
      HBRSS_ST_HRST = 2'b01,
      HBRSS_ST_RUN = 2'b11
   } hbrss_state_type;
endpackage
`default_nettype wire

// >>> hbrss_rst_sync.sv
// Reset synchroniser: asynchronous assert, clocked release
`timescale 1ns/10ps
`default_nettype none
module hbrss_rst_sync #(
   parameter int STAGES = 2
) (
   // Clock and raw reset
   input wire logic clk_sys_in,
   input wire logic rst_raw_in,
   // Synchronised reset
   output logic rst_sync_out
);
   logic [STAGES-1:0] shift_r;

   // Assert at once, release after STAGES edges
   always_ff @(posedge clk_sys_in or posedge rst_raw_in) begin
      if (rst_raw_in) begin
         shift_r <= {STAGES{1'b1}};
      end else begin
         shift_r <= {shift_r[STAGES-2:0], 1'b0};
      end
   end

   assign rst_sync_out = shift_r[STAGES-1];
endmodule // hbrss_rst_sync
`default_nettype wire

// >>> hbrss_top.sv
// Host-bus reset and system-signal top level
`timescale 1ns/10ps
`default_nettype none
`include "hbrss_params.svh"

module hbrss_top
   import hbrss_pkg::*;
(
   // Clock and resets
   input wire logic clk_sys_in,
   input wire logic srst_in,
   input wire logic global_rst_n_in,
   input wire logic host_rst_n_in,
   // Strap and core events
   input wire logic card_mode_strap_in,
   input wire logic core_irq_in,
   input wire logic card_interrupt_in,
   // Register loads from core logic
   input wire logic ctx_load_in,
   input wire logic [`HBRSS_CTX_W-1:0] ctx_data_in,
   input wire logic vend_load_in,
   input wire logic [`HBRSS_VEND_W-1:0] vend_data_in,
   input wire logic ctl_load_in,
   input wire logic [`HBRSS_CTL_W-1:0] ctl_data_in,
   // Interrupt pin (open drain, active low on the wire)
   output logic host_interrupt_out,
   output logic host_interrupt_oe_out,
   // Status towards core
   output logic core_enable_out,
   output logic outputs_float_out,
   output logic grst_short_out,
   output logic [`HBRSS_CTX_W-1:0] ctx_bits_out,
   output logic [`HBRSS_VEND_W-1:0] vend_bits_out,
   output logic [`HBRSS_CTL_W-1:0] ctl_bits_out
);
   localparam int GRST_MIN_CYC = `HBRSS_GRST_MIN_CYC;

   logic grst_raw;
   logic hrst_raw;
   logic grst_sync;
   logic hrst_sync;
   hbrss_state_type state_r;
   hbrss_state_type state_nxt;
   logic [2:0] evt_meta_r;
   logic [2:0] evt_r;
   logic [21:0] grst_cnt_r;
   logic grst_short_r;
   logic [`HBRSS_CTX_W-1:0] ctx_r;
   logic [`HBRSS_VEND_W-1:0] vend_r;
   logic [`HBRSS_CTL_W-1:0] ctl_r;
   logic irq_sel;
   logic irq_r;
   logic running;
   logic in_grst;
   logic grst_release;
   logic load_ok;
   logic ctx_take;
   logic vend_take;
   logic ctl_take;
   logic strap_sync;
   logic card_irq_sync;
   logic core_irq_sync;

   // Next state from synced resets; unknown reads as global
   function automatic hbrss_state_type hbrss_pick_state(
      input logic grst,
      input logic hrst
   );
      hbrss_state_type pick;
      case ({grst, hrst})
         2'b00: pick = HBRSS_ST_RUN;
         2'b01: pick = HBRSS_ST_HRST;
         default: pick = HBRSS_ST_GRST;
      endcase
      return pick;
   endfunction

   // Saturating step for the hold monitor
   function automatic logic [21:0] hbrss_sat_inc(
      input logic [21:0] value
   );
      logic [21:0] result;
      result = value;
      if (value != 22'h3FFFFF) begin
         result = value + 22'h000001;
      end
      return result;
   endfunction

   // Raw reset levels; local reset counts as global
   assign grst_raw = ~global_rst_n_in | srst_in;
   assign hrst_raw = ~host_rst_n_in | grst_raw;

   // Reset synchronisers
   hbrss_rst_sync #(.STAGES(`HBRSS_SYNC_STAGES)) u_grst_sync (
      .clk_sys_in(clk_sys_in),
      .rst_raw_in(grst_raw),
      .rst_sync_out(grst_sync)
   );

   hbrss_rst_sync #(.STAGES(`HBRSS_SYNC_STAGES)) u_hrst_sync (
      .clk_sys_in(clk_sys_in),
      .rst_raw_in(hrst_raw),
      .rst_sync_out(hrst_sync)
   );

   // State decode; global reset has priority
   always_comb begin
      case (state_r)
         HBRSS_ST_GRST: begin
            state_nxt = hbrss_pick_state(grst_sync, hrst_sync);
         end
         HBRSS_ST_HRST: begin
            state_nxt = hbrss_pick_state(grst_sync, hrst_sync);
         end
         HBRSS_ST_RUN: begin
            state_nxt = hbrss_pick_state(grst_sync, hrst_sync);
         end
         default: begin
            state_nxt = HBRSS_ST_GRST;
         end
      endcase
   end

   // State register
   always_ff @(posedge clk_sys_in) begin
      state_r <= state_nxt;
   end

   // Pin inputs pass two flip-flops
   always_ff @(posedge clk_sys_in) begin
      evt_meta_r <= {card_mode_strap_in, card_interrupt_in, core_irq_in};
      evt_r <= evt_meta_r;
   end

   // Synced pin levels
   assign strap_sync = evt_r[2];
   assign card_irq_sync = evt_r[1];
   assign core_irq_sync = evt_r[0];

   // Global reset length monitor (partner obligation)
   always_ff @(posedge clk_sys_in) begin
      if (srst_in || !grst_sync) begin
         grst_cnt_r <= 22'h000000;
      end else begin
         grst_cnt_r <= hbrss_sat_inc(grst_cnt_r);
      end
   end

   // Release edge of the global reset
   assign in_grst = (state_r == HBRSS_ST_GRST);
   assign grst_release = in_grst & ~grst_sync;

   // Short-hold flag, judged at each release
   always_ff @(posedge clk_sys_in) begin
      if (grst_release) begin
         grst_short_r <= (grst_cnt_r < 22'(GRST_MIN_CYC));
      end
   end

   // Loads refused while either synced reset stands
   assign load_ok = ~hrst_sync;
   assign ctx_take = load_ok & ctx_load_in;
   assign vend_take = load_ok & vend_load_in;
   assign ctl_take = load_ok & ctl_load_in;

   // Context and vendor bits: only global reset clears them
   always_ff @(posedge clk_sys_in) begin
      if (grst_sync) begin
         ctx_r <= `HBRSS_CTX_RST;
         vend_r <= `HBRSS_VEND_RST;
      end else begin
         if (ctx_take) begin
            ctx_r <= ctx_data_in;
         end
         if (vend_take) begin
            vend_r <= vend_data_in;
         end
      end
   end

   // Ordinary registers: cleared by either reset
   always_ff @(posedge clk_sys_in) begin
      if (hrst_sync) begin
         ctl_r <= `HBRSS_CTL_RST;
      end else if (ctl_take) begin
         ctl_r <= ctl_data_in;
      end
   end

   // Interrupt source select by strap
   assign running = (state_r == HBRSS_ST_RUN);
   assign irq_sel = strap_sync ? core_irq_sync : card_irq_sync;

   // Interrupt register, cleared by any reset
   always_ff @(posedge clk_sys_in) begin
      if (hrst_sync) begin
         irq_r <= 1'b0;
      end else begin
         irq_r <= irq_sel;
      end
   end

   // Outputs floated and core stopped during any reset
   assign core_enable_out = running;
   assign outputs_float_out = ~running;
   assign host_interrupt_out = 1'b0;
   assign host_interrupt_oe_out = running & irq_r;
   assign grst_short_out = grst_short_r;
   assign ctx_bits_out = ctx_r;
   assign vend_bits_out = vend_r;
   assign ctl_bits_out = ctl_r;
endmodule // hbrss_top
`default_nettype wire

// >>> hbrss_sva.sv
// Checker for the reset and system-signal block
`timescale 1ns/10ps
`default_nettype none
module hbrss_sva (
   // Clock, resets and events
   input wire logic clk_sys_in, srst_in, global_rst_n_in, host_rst_n_in,
   input wire logic card_mode_strap_in, core_irq_in, card_interrupt_in,
   input wire logic ctl_load_in,
   input wire logic [7:0] ctl_data_in,
   // Outputs watched
   input wire logic host_interrupt_oe_out, core_enable_out, outputs_float_out,
   input wire logic [7:0] ctx_bits_out, vend_bits_out, ctl_bits_out
);
   default clocking @(posedge clk_sys_in); endclocking
   default disable iff (srst_in);
   // Both resets released
   sequence s_quiet; global_rst_n_in && host_rst_n_in; endsequence
   a_grst_float: assert property (!global_rst_n_in |=>
      outputs_float_out && !host_interrupt_oe_out) else $error("live");
   a_grst_clear: assert property (!global_rst_n_in |=>
      (ctx_bits_out | vend_bits_out | ctl_bits_out) == 8'h00) else $error("clr");
   a_hrst_keep: assert property (global_rst_n_in && !host_rst_n_in |=>
      !global_rst_n_in || ($stable(ctx_bits_out) && $stable(vend_bits_out)
      && ctl_bits_out == 8'h00)) else $error("keep");
   a_hrst_stop: assert property (!host_rst_n_in |=>
      !core_enable_out) else $error("run");
   a_wake_late: assert property (s_quiet [*5] |->
      core_enable_out) else $error("late");
   a_rel_sync: assert property ($rose(core_enable_out) |->
      $past(host_rst_n_in, 2) && $past(global_rst_n_in, 2)) else $error("rel");
   a_ctl_take: assert property (ctl_load_in && core_enable_out &&
      global_rst_n_in && host_rst_n_in |=> !(global_rst_n_in && host_rst_n_in)
      || ctl_bits_out == $past(ctl_data_in)) else $error("load");
   a_irq_card: assert property ((core_enable_out && !card_mode_strap_in
      && card_interrupt_in) [*5] |-> host_interrupt_oe_out) else $error("ci");
   a_irq_host: assert property ((core_enable_out && card_mode_strap_in
      && core_irq_in) [*5] |-> host_interrupt_oe_out) else $error("hi");
endmodule // hbrss_sva
`default_nettype wire

// >>> hbrss_sysrst.sv
// System reset logic facing the block
`timescale 1ns/10ps
`default_nettype none
module hbrss_sysrst #(
   parameter int HOLD = 20
) (
   // Clock and host-bus reset request
   input wire logic clk_sys_in,
   input wire logic host_req_in,
   // Reset wires
   output logic global_rst_n_out,
   output wire logic host_rst_n_out
);
   // One power-on pulse only, hold shortened
   initial begin
      global_rst_n_out = 1'b0;
      repeat (HOLD) @(posedge clk_sys_in);
      #1 global_rst_n_out = 1'b1;
   end
   // Host-bus reset on a wire of its own
   assign host_rst_n_out = !host_req_in;
endmodule // hbrss_sysrst
`default_nettype wire

// >>> tb_host_bus_reset_and_system_signals.sv
// Testbench for the reset and system-signal block
`timescale 1ns/10ps
`default_nettype none
`define CHK(a,b) begin checks_done++; if ((a) !== (b)) begin num_errors++; \
$display("Error %0t: value differs", $time); end end
module tb_host_bus_reset_and_system_signals;
   logic clk_sys_in = 0, srst_in = 1, host_req_in = 0, lds = 0;
   logic card_mode_strap_in = 1, core_irq_in = 0, card_interrupt_in = 0;
   logic ctx_load_in = 0, vend_load_in = 0, ctl_load_in = 0;
   logic [7:0] ctx_data_in = 0, vend_data_in = 0, ctl_data_in = 0, q[$];
   logic [7:0] ctx_bits_out, vend_bits_out, ctl_bits_out;
   logic global_rst_n_in, host_rst_n_in, host_interrupt_out;
   logic host_interrupt_oe_out, core_enable_out, outputs_float_out;
   logic grst_short_out;
   int num_errors = 0, checks_done = 0;
   always #2.5 clk_sys_in = !clk_sys_in;
   hbrss_sysrst i_hbrss_sysrst (.clk_sys_in, .host_req_in,
      .global_rst_n_out(global_rst_n_in), .host_rst_n_out(host_rst_n_in));
   hbrss_top i_hbrss_top (.clk_sys_in, .srst_in, .global_rst_n_in,
      .host_rst_n_in, .card_mode_strap_in, .core_irq_in, .card_interrupt_in,
      .ctx_load_in, .ctx_data_in, .vend_load_in, .vend_data_in, .ctl_load_in,
      .ctl_data_in, .host_interrupt_out, .host_interrupt_oe_out,
      .core_enable_out, .outputs_float_out, .grst_short_out, .ctx_bits_out,
      .vend_bits_out, .ctl_bits_out);
   task automatic step(int n); repeat (n) @(posedge clk_sys_in); #1; endtask
   task automatic wait_en();
      repeat (60) if (core_enable_out !== 1'b1) step(1);
      `CHK(core_enable_out, 1'b1)
   endtask
   task automatic conclude();
      $display("errors %0d checks %0d", num_errors, checks_done);
      if (num_errors == 0 && checks_done > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // Loaded words appear one edge later
   always @(posedge clk_sys_in) begin
      if (lds) `CHK(ctl_bits_out, q.pop_front())
      lds <= ctl_load_in;
   end
   initial begin
      void'($urandom(40));
      step(5);
      srst_in = 0;
      wait_en();
      `CHK(ctx_bits_out | vend_bits_out | ctl_bits_out, 8'h00)
      `CHK(grst_short_out, 1'b1)
      ctx_data_in = 8'($urandom);
      vend_data_in = 8'($urandom);
      {ctx_load_in, vend_load_in} = 2'b11;
      for (int i = 0; i < 4; i++) begin
         ctl_data_in = 8'($urandom);
         ctl_load_in = 1;
         q.push_back(ctl_data_in);
         step(1);
      end
      {ctx_load_in, vend_load_in, ctl_load_in} = 3'b000;
      step(2);
      host_req_in = 1;
      step(3);
      `CHK(outputs_float_out, 1'b1)
      `CHK({ctx_bits_out, vend_bits_out, ctl_bits_out},
         {ctx_data_in, vend_data_in, 8'h00})
      host_req_in = 0;
      wait_en();
      core_irq_in = 1;
      step(6);
      `CHK(host_interrupt_oe_out, 1'b1)
      card_mode_strap_in = 0;
      step(6);
      `CHK(host_interrupt_oe_out, 1'b0)
      card_interrupt_in = 1;
      step(6);
      `CHK({host_interrupt_oe_out, host_interrupt_out}, 2'b10)
      srst_in = 1;
      step(2);
      `CHK({outputs_float_out, host_interrupt_oe_out}, 2'b10)
      srst_in = 0;
      wait_en();
      `CHK(ctx_bits_out | vend_bits_out, 8'h00)
      conclude();
   end
   // Watchdog
   initial begin
      #20000;
      num_errors++;
      conclude();
   end
endmodule // tb_host_bus_reset_and_system_signals
bind hbrss_top hbrss_sva i_hbrss_sva (.clk_sys_in, .srst_in,
   .global_rst_n_in, .host_rst_n_in, .card_mode_strap_in, .core_irq_in,
   .card_interrupt_in, .ctl_load_in, .ctl_data_in, .host_interrupt_oe_out,
   .core_enable_out, .outputs_float_out, .ctx_bits_out, .vend_bits_out,
   .ctl_bits_out);
`default_nettype wire
